// >>> verification/port_pin_select_props.sv
// Checker for the pin-select port, bound to the top module.
// Sees only the top ports; one clock domain, synchronous reset.
`timescale 1ns/1ps
module port_pin_select_props #(parameter NPINS = 8) (
  // Clock and control
  input wire mclk, input wire rst_n, input wire clk_en,
  // APB
  input wire psel, input wire penable, input wire pwrite, input wire [11:0] paddr,
  input wire [31:0] pwdata, input wire pready, input wire [31:0] prdata, input wire pslverr,
  // Pins and switches
  input wire [NPINS-1:0] pad_in, input wire [NPINS-1:0] pad_out_ff,
  input wire [NPINS-1:0] pad_oe_ff, input wire [NPINS-1:0] analog_input_channel_ff,
  input wire [NPINS-1:0] conv_route_ff, input wire amp0_in_en_ff, input wire amp1_in_en_ff,
  input wire amplifier_zero_output_ff, input wire amplifier_one_output_ff,
  input wire [3:0] conv_channel_ff
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire apb_wr = psel && penable && pwrite && clk_en;
  chk_drive_latch: assert property ((pad_out_ff & ~pad_oe_ff) == 0)
    else $error("pad driven on a pin that is not an output");
  chk_digital_analog: assert property ((pad_oe_ff & analog_input_channel_ff) == 0)
    else $error("pin both driven and analog");
  chk_route_analog: assert property ((conv_route_ff & ~analog_input_channel_ff) == 0)
    else $error("converter route on a non-analog pin");
  chk_route_chan: assert property ((conv_channel_ff < 4'h8) ?
    conv_route_ff == (8'h01 << conv_channel_ff[2:0]) : conv_route_ff == 0)
    else $error("channel number and route disagree");
  chk_amp_inputs: assert property ((amp0_in_en_ff |-> analog_input_channel_ff[0]
    && analog_input_channel_ff[2]) and (amp1_in_en_ff |-> analog_input_channel_ff[5]
    && analog_input_channel_ff[7])) else $error("amplifier input on non-analog pin");
  chk_amp_outputs: assert property ((amplifier_zero_output_ff |-> analog_input_channel_ff[1])
    and (amplifier_one_output_ff |-> analog_input_channel_ff[6]))
    else $error("amplifier output on non-analog pin");
  chk_reset_state: assert property ($rose(rst_n) |-> pad_oe_ff == 0 &&
    analog_input_channel_ff == 8'hE7 && conv_route_ff == 0 && conv_channel_ff == 4'h8)
    else $error("pins not analog inputs after reset");
  chk_unbonded_idle: assert property ((pad_oe_ff[4:3] | analog_input_channel_ff[4:3]) == 0)
    else $error("unbonded pin in use");
  chk_hold_nowrite: assert property ((!apb_wr) [*2] |=> $stable(pad_oe_ff) &&
    $stable(analog_input_channel_ff) && $stable(conv_route_ff))
    else $error("pin function changed without a write");
  chk_err_refused: assert property (psel && penable && (paddr > 12'h018 ||
    (pwrite && paddr >= 12'h014)) |-> pslverr && pready)
    else $error("refused access not flagged");
  cov_route: cover property (conv_route_ff != 0);
  cov_amp_out: cover property (amplifier_zero_output_ff && conv_channel_ff == 4'h8);
  cov_drive: cover property (pad_oe_ff != 0);
endmodule // port_pin_select_props

bind port_pin_select port_pin_select_props #(.NPINS(NPINS)) props_inst (
  .mclk(mclk), .rst_n(rst_n), .clk_en(clk_en),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .pad_in(pad_in), .pad_out_ff(pad_out_ff), .pad_oe_ff(pad_oe_ff),
  .analog_input_channel_ff(analog_input_channel_ff), .conv_route_ff(conv_route_ff),
  .amp0_in_en_ff(amp0_in_en_ff), .amp1_in_en_ff(amp1_in_en_ff),
  .amplifier_zero_output_ff(amplifier_zero_output_ff),
  .amplifier_one_output_ff(amplifier_one_output_ff),
  .conv_channel_ff(conv_channel_ff)
);

// >>> verification/port_pin_select_tb.sv
// Self-checking bench for the pin-select port over APB.
// Assumes an APB slave on mclk and pin outputs one edge behind the registers.
`timescale 1ns/1ps
module port_pin_select_tb;
  logic mclk, rst_n, clk_en, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [7:0] pad_in, pad_out_ff, pad_oe_ff, ain, rt, l, d, c, s, a;
  logic [7:0] e_oe, e_out, e_ain, e_rt, e_bad, e_pin;
  logic [3:0] ch, e_ch, e_amp;
  logic a0i, a1i, a0o, a1o, erv;
  logic [39:0] corner [4] = '{40'h00FFFF0108, 40'h00FFFF0888, 40'hA50F000200, 40'h5A3CF00580};
  int bad_count = 0, num_checks = 0, cyc = 0, seed;
  port_pin_select port_pin_select_inst (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .pad_in(pad_in),
    .pad_out_ff(pad_out_ff), .pad_oe_ff(pad_oe_ff), .analog_input_channel_ff(ain),
    .conv_route_ff(rt), .amp0_in_en_ff(a0i), .amp1_in_en_ff(a1i),
    .amplifier_zero_output_ff(a0o), .amplifier_one_output_ff(a1o), .conv_channel_ff(ch));
  always #50 mclk = ~mclk;
  // Cycle ceiling well above the roughly 1700 cycles the run needs
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Request held until pready is seen high; only then released
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    @(posedge mclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= ad; pwdata <= wd;
    @(posedge mclk);
    penable <= 1;
    // No assumed latency: only the bench ceiling ends this wait
    do @(posedge mclk); while (pready !== 1'b1);
    rdv = prdata; erv = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic rdc(input logic [11:0] ad, input logic [31:0] e, input logic ee);
    apb(0, ad, 0);
    chk(rdv, e);
    chk(erv, ee);
  endtask
  // Expected pin functions from the register settings
  function automatic void calc();
    logic [7:0] sel, g;
    sel = s[3] ? 8'h00 : 8'h01 << s[2:0];
    e_bad = ((~c & sel) | (c & ~d) | {1'b0, a[7] & ~c[6], 4'h0, a[3] & ~c[1], 1'b0}) & 8'hE7;
    g = 8'hE7 & ~e_bad;
    e_oe = g & ~c & ~d; e_out = e_oe & l; e_ain = g & c & d; e_rt = e_ain & sel;
    e_ch = (e_rt != 0) ? {1'b0, s[2:0]} : 4'h8;
    e_amp = {a[7] & e_ain[6], a[3] & e_ain[1], a[7] & e_ain[5] & e_ain[7],
             a[3] & e_ain[0] & e_ain[2]};
    e_pin = g & ~c & d & pad_in;
  endfunction
  task automatic check_pins();
    calc();
    // Pin outputs are registered one edge after the register store
    @(posedge mclk);
    @(negedge mclk);
    chk(pad_oe_ff, e_oe);
    chk(pad_out_ff, e_out);
    chk(ain, e_ain);
    chk(rt, e_rt);
    chk(ch, e_ch);
    chk({a1o, a0o, a1i, a0i}, e_amp);
  endtask
  initial begin
    mclk = 0; rst_n = 0; clk_en = 1; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; pad_in = 0;
    seed = $urandom(11514);
    repeat (8) @(posedge mclk);
    rst_n <= 1;
    l = 0; d = 8'hFF; c = 8'hFF; s = 8'h08; a = 0;
    check_pins();
    rdc(12'h004, 32'hFF, 0);
    rdc(12'h008, 32'hFF, 0);
    rdc(12'h00C, 32'h08, 0);
    rdc(12'h01C, 32'h0, 1);
    apb(1, 12'h014, 32'hFF);
    chk(erv, 1);
    // A write while the clock enable is low must not reach the latch
    clk_en <= 0;
    apb(1, 12'h000, 32'hFF);
    clk_en <= 1;
    rdc(12'h000, 32'h00, 0);
    for (int i = 0; i < 60; i++) begin
      if (i < 4) {l, d, c, s, a} = corner[i];
      else {l, d, c, s, a} = {$urandom, $urandom} & 40'hFFFFFF0FFF;
      pad_in <= $urandom;
      apb(1, 12'h000, {24'h0, l});
      apb(1, 12'h004, {24'h0, d});
      apb(1, 12'h008, {24'h0, c});
      apb(1, 12'h00C, {24'h0, s});
      apb(1, 12'h010, {24'h0, a});
      check_pins();
      rdc(12'h004, {24'h0, d}, 0);
      rdc(12'h010, {24'h0, a}, 0);
      rdc(12'h018, {24'h0, e_bad}, 0);
      rdc(12'h014, {24'h0, e_pin}, 0);
    end
    finish_test();
  end
endmodule // port_pin_select_tb

// >>> verilog/port_pin_select.v
// Pin-function selection for an eight-position port, six pins bonded.
// Assumes an APB master on mclk; pad inputs synchronous to mclk.
//
// Summary of operation
// RULE1: Each pin has an output latch that drives the pin when it is a digital output.
// RULE2: Each pin has its own direction bit choosing input or output.
// RULE3: After reset every pin is an analog input with digital drive and input off.
// RULE4: Software sets configuration, direction, amplifier enable and channel to match.
// RULE5: A digital pin not selected as channel is a digital input or output by direction.
// RULE6: An analog input pin with amplifier off and its channel selected goes to the converter.
// RULE7: An analog input pin whose channel is not selected stays analog and unsampled.
// RULE8: An amplifier input pin with the amplifier on feeds it, and the converter if selected.
// RULE9: Amplifier output pins 1 and 6 with amplifier on and selected drive and convert.
// RULE10: Amplifier output pins with amplifier on and not selected carry the output only.
// RULE11: Amplifier enables sit at bits 3 and 7 of the amplifier control register.
// RULE12: Software avoids the prohibited combinations, which are flagged in status.
`timescale 1ns/1ps
`include "port_pin_select_regs.vh"

module port_pin_select #(
  parameter NPINS = 8,
  parameter [7:0] BONDED = `BONDED_MASK
) (
  // Clock, enable and reset
  input wire mclk,
  input wire rst_n,
  input wire clk_en,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // Port pads
  input wire [NPINS-1:0] pad_in,
  output reg [NPINS-1:0] pad_out_ff,
  output reg [NPINS-1:0] pad_oe_ff,
  // Analog switch controls
  output reg [NPINS-1:0] analog_input_channel_ff,
  output reg [NPINS-1:0] conv_route_ff,
  output reg amp0_in_en_ff,
  output reg amp1_in_en_ff,
  output reg amplifier_zero_output_ff,
  output reg amplifier_one_output_ff,
  // Converter channel for the analog converter
  output reg [`CHAN_SEL_W-1:0] conv_channel_ff
);

  // Pin roles within the port
  localparam AMP0_IN_A = 0;
  localparam AMP0_OUT = 1;
  localparam AMP0_IN_B = 2;
  localparam AMP1_IN_A = 5;
  localparam AMP1_OUT = 6;
  localparam AMP1_IN_B = 7;

  wire [7:0] data_latch_ff;
  wire [7:0] port_direction_reg;
  wire [7:0] analog_digital_pin_config;
  wire [7:0] converter_channel_select;
  wire [7:0] amplifier_control_reg;
  wire amplifier_enable_bit0;
  wire amplifier_enable_bit1;
  reg [NPINS-1:0] pin_input_ff;
  reg [NPINS-1:0] bad_combo_ff;
  reg [NPINS-1:0] nxt_out;
  reg [NPINS-1:0] nxt_oe;
  reg [NPINS-1:0] nxt_ain;
  reg [NPINS-1:0] nxt_conv;
  reg [NPINS-1:0] nxt_bad;
  reg [NPINS-1:0] nxt_in;
  reg [31:0] nxt_rdata;
  reg wr_en;
  reg [2:0] wr_idx;
  reg addr_ok;
  integer i;

  // Single-cycle access: no wait states, so pready is tied high
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  // Which channel a pin selects, shared by routing and the combination check
  function chan_hit;
    input [7:0] sel;
    input integer pin;
    begin
      chan_hit = (sel[`CHAN_SEL_W-1:0] == pin[`CHAN_SEL_W-1:0]);
    end
  endfunction

  // Pin owns an amplifier output
  function is_amp_out;
    input integer pin;
    begin
      is_amp_out = (pin == AMP0_OUT) || (pin == AMP1_OUT);
    end
  endfunction

  // Amplifier enable for the amplifier that serves a pin
  function amp_en_for;
    input integer pin;
    input a0;
    input a1;
    begin
      amp_en_for = (pin < AMP1_IN_A) ? a0 : a1;
    end
  endfunction

  port_reg_store #(
    .DW(8)
  ) u_regs (
    .mclk(mclk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .wr_en(wr_en),
    .wr_idx(wr_idx),
    .wr_data(pwdata[7:0]),
    .data_latch_ff(data_latch_ff),
    .direction_ff(port_direction_reg),
    .pin_config_ff(analog_digital_pin_config),
    .chan_select_ff(converter_channel_select),
    .amp_control_ff(amplifier_control_reg)
  );

  assign amplifier_enable_bit0 = amplifier_control_reg[`AMP0_EN_BIT]; // [RULE11]
  assign amplifier_enable_bit1 = amplifier_control_reg[`AMP1_EN_BIT]; // [RULE11]

  // Address decode and write strobe
  always @* begin
    wr_en = 1'b0;
    wr_idx = `IDX_DATA_LATCH;
    addr_ok = 1'b1;
    nxt_rdata = 32'h0000_0000;
    case (paddr)
      `OFS_DATA_LATCH: begin
        wr_idx = `IDX_DATA_LATCH;
        nxt_rdata = {24'h00_0000, data_latch_ff};
      end
      `OFS_DIRECTION: begin
        wr_idx = `IDX_DIRECTION;
        nxt_rdata = {24'h00_0000, port_direction_reg};
      end
      `OFS_PIN_CONFIG: begin
        wr_idx = `IDX_PIN_CONFIG;
        nxt_rdata = {24'h00_0000, analog_digital_pin_config};
      end
      `OFS_CHAN_SELECT: begin
        wr_idx = `IDX_CHAN_SELECT;
        nxt_rdata = {24'h00_0000, converter_channel_select};
      end
      `OFS_AMP_CONTROL: begin
        wr_idx = `IDX_AMP_CONTROL;
        nxt_rdata = {24'h00_0000, amplifier_control_reg};
      end
      `OFS_PIN_INPUT: begin
        addr_ok = !pwrite;
        nxt_rdata = {24'h00_0000, pin_input_ff};
      end
      `OFS_PIN_STATUS: begin
        addr_ok = !pwrite;
        nxt_rdata = {24'h00_0000, bad_combo_ff};
      end
      default: begin
        addr_ok = 1'b0;
      end
    endcase
    // Writes to the read-only words are refused, not stored
    if (psel && penable && pwrite && addr_ok && paddr < `OFS_PIN_INPUT)
      wr_en = 1'b1;
  end

  // Read data sampled in the setup cycle, valid through the access phase
  always @(posedge mclk) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en && psel && !penable) begin
      prdata <= pwrite ? 32'h0000_0000 : nxt_rdata;
    end
  end

  // Per-pin function decode
  always @* begin
    nxt_out = {NPINS{1'b0}};
    nxt_oe = {NPINS{1'b0}};
    nxt_ain = {NPINS{1'b0}};
    nxt_conv = {NPINS{1'b0}};
    nxt_bad = {NPINS{1'b0}};
    nxt_in = {NPINS{1'b0}};
    for (i = 0; i < NPINS; i = i + 1) begin
      if (BONDED[i]) begin
        if (!analog_digital_pin_config[i]) begin
          // Digital mode; an amplifier driving this pin would fight the pad
          if (chan_hit(converter_channel_select, i) || (is_amp_out(i) &&
              amp_en_for(i, amplifier_enable_bit0, amplifier_enable_bit1))) begin
            nxt_bad[i] = 1'b1; // [RULE12]
          end else if (port_direction_reg[i]) begin
            nxt_in[i] = pad_in[i]; // [RULE5]
          end else begin
            nxt_oe[i] = 1'b1; // [RULE5]
            nxt_out[i] = data_latch_ff[i]; // [RULE1]
          end
        end else if (!port_direction_reg[i]) begin
          nxt_bad[i] = 1'b1; // [RULE12]
        end else begin
          nxt_ain[i] = 1'b1; // [RULE7]
          nxt_conv[i] = chan_hit(converter_channel_select, i); // [RULE6] [RULE8] [RULE9]
        end
      end
    end
  end

  // Registered pad and analog switch controls
  always @(posedge mclk) begin
    if (!rst_n) begin
      pad_out_ff <= {NPINS{1'b0}}; // [RULE3]
      pad_oe_ff <= {NPINS{1'b0}}; // [RULE3]
      pin_input_ff <= {NPINS{1'b0}}; // [RULE3]
      analog_input_channel_ff <= BONDED; // [RULE3]
      conv_route_ff <= {NPINS{1'b0}};
      bad_combo_ff <= {NPINS{1'b0}};
      amp0_in_en_ff <= 1'b0;
      amp1_in_en_ff <= 1'b0;
      amplifier_zero_output_ff <= 1'b0;
      amplifier_one_output_ff <= 1'b0;
      conv_channel_ff <= `CHAN_NONE;
    end else if (clk_en) begin
      pad_out_ff <= nxt_out;
      pad_oe_ff <= nxt_oe;
      pin_input_ff <= nxt_in;
      analog_input_channel_ff <= nxt_ain;
      conv_route_ff <= nxt_conv;
      bad_combo_ff <= nxt_bad;
      // Amplifier inputs need both pins analog inputs
      amp0_in_en_ff <= amplifier_enable_bit0 && nxt_ain[AMP0_IN_A]
                       && nxt_ain[AMP0_IN_B]; // [RULE8]
      amp1_in_en_ff <= amplifier_enable_bit1 && nxt_ain[AMP1_IN_A]
                       && nxt_ain[AMP1_IN_B]; // [RULE8]
      amplifier_zero_output_ff <= amplifier_enable_bit0 && nxt_ain[AMP0_OUT]; // [RULE9] [RULE10]
      amplifier_one_output_ff <= amplifier_enable_bit1 && nxt_ain[AMP1_OUT]; // [RULE9] [RULE10]
      conv_channel_ff <= (|nxt_conv) ? converter_channel_select[`CHAN_SEL_W-1:0]
                         : `CHAN_NONE; // [RULE6]
    end
  end

endmodule // port_pin_select

// >>> verilog/port_pin_select_regs.vh
// Register offsets, field positions and reset values of the pin-select port.
// Included by the port top and its register store; definitions only.
`ifndef PORT_PIN_SELECT_REGS_VH
`define PORT_PIN_SELECT_REGS_VH

// Byte addresses on APB (one aligned word each)
`define OFS_DATA_LATCH 12'h000
`define OFS_DIRECTION 12'h004
`define OFS_PIN_CONFIG 12'h008
`define OFS_CHAN_SELECT 12'h00C
`define OFS_AMP_CONTROL 12'h010
`define OFS_PIN_INPUT 12'h014
`define OFS_PIN_STATUS 12'h018

// Register store indices
`define IDX_DATA_LATCH 3'h0
`define IDX_DIRECTION 3'h1
`define IDX_PIN_CONFIG 3'h2
`define IDX_CHAN_SELECT 3'h3
`define IDX_AMP_CONTROL 3'h4

// Amplifier enable bits in the amplifier control register
`define AMP0_EN_BIT 3
`define AMP1_EN_BIT 7

// Channel select field width and the "no channel" code
`define CHAN_SEL_W 4
`define CHAN_NONE 4'h8

// Reset values: all pins analog, all inputs, latch clear, amplifiers off
`define RST_DATA_LATCH 8'h00
`define RST_DIRECTION 8'hFF
`define RST_PIN_CONFIG 8'hFF
`define RST_CHAN_SELECT 8'h08
`define RST_AMP_CONTROL 8'h00

// Bonded pin mask of the eight-position port (positions 0-2 and 5-7)
`define BONDED_MASK 8'hE7

`endif

// >>> verilog/port_reg_store.v
// Small register store for the five writable port registers.
// Assumes writes come one per cycle from the APB decode in the port top.
`timescale 1ns/1ps
`include "port_pin_select_regs.vh"

module port_reg_store #(
  parameter DW = 8
) (
  // Clock, enable and reset
  input wire mclk,
  input wire rst_n,
  input wire clk_en,
  // Write port
  input wire wr_en,
  input wire [2:0] wr_idx,
  input wire [DW-1:0] wr_data,
  // Stored values
  output reg [DW-1:0] data_latch_ff,
  output reg [DW-1:0] direction_ff,
  output reg [DW-1:0] pin_config_ff,
  output reg [DW-1:0] chan_select_ff,
  output reg [DW-1:0] amp_control_ff
);

  always @(posedge mclk) begin
    if (!rst_n) begin
      data_latch_ff <= `RST_DATA_LATCH;
      direction_ff <= `RST_DIRECTION; // [RULE3]
      pin_config_ff <= `RST_PIN_CONFIG; // [RULE3]
      chan_select_ff <= `RST_CHAN_SELECT;
      amp_control_ff <= `RST_AMP_CONTROL;
    end else if (clk_en && wr_en) begin
      case (wr_idx)
        `IDX_DATA_LATCH: data_latch_ff <= wr_data; // [RULE1]
        `IDX_DIRECTION: direction_ff <= wr_data; // [RULE2]
        `IDX_PIN_CONFIG: pin_config_ff <= wr_data;
        `IDX_CHAN_SELECT: chan_select_ff <= wr_data;
        `IDX_AMP_CONTROL: amp_control_ff <= wr_data; // [RULE11]
        default: data_latch_ff <= data_latch_ff;
      endcase
    end
  end

endmodule // port_reg_store
